// ### shared/sac_pkg.sv
package sac_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL_A      = 8'h00; // control_status_a
	localparam logic [7:0] OFS_CTRL_B      = 8'h04; // control_status_b
	localparam logic [7:0] OFS_CHAN_REF    = 8'h08; // channel_ref_register
	localparam logic [7:0] OFS_RES_LOW     = 8'h0C; // result_low_byte
	localparam logic [7:0] OFS_RES_HIGH    = 8'h10; // result_high_byte
	localparam logic [7:0] OFS_TRIG_FLAGS  = 8'h14; // trigger source flags

	// ----------------------------------------
	// control_status_a fields
	// ----------------------------------------
	localparam int BIT_ENABLE    = 7;
	localparam int BIT_START     = 6;
	localparam int BIT_AUTO      = 5;
	localparam int BIT_DONE      = 4;
	localparam int BIT_DONE_IE   = 3;
	localparam int PRESC_LSB     = 0;
	localparam int PRESC_W       = 3;

	// ----------------------------------------
	// control_status_b fields
	// ----------------------------------------
	localparam int BIT_POWER_GATE = 7;
	localparam int TSEL_LSB       = 0;
	localparam int TSEL_W         = 3;

	// ----------------------------------------
	// channel_ref_register fields
	// ----------------------------------------
	localparam int REF_LSB   = 6;
	localparam int BIT_LEFT  = 5;
	localparam int CHAN_LSB  = 0;
	localparam int CHAN_W    = 4;

	// channel codes beyond the eight pins
	localparam logic [3:0] CHAN_BANDGAP = 4'hE;
	localparam logic [3:0] CHAN_GROUND  = 4'hF;

	// trigger source codes
	localparam logic [2:0] TSEL_OWN_DONE = 3'h0;
	localparam logic [2:0] TSEL_EXT_PIN  = 3'h1;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0] RST_CTRL_A   = 8'h00;
	localparam logic [7:0] RST_CTRL_B   = 8'h00;
	localparam logic [7:0] RST_CHAN_REF = 8'h00;
	localparam int RESULT_W      = 10;
	localparam int FIRST_TICKS   = 25; // converter clocks, first conversion
	localparam int NORMAL_TICKS  = 13; // converter clocks, normal conversion
	localparam int TICK_CNT_W    = 5;
	localparam int PRESC_CNT_W   = 7;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// selection applied to the analog front end
	typedef struct packed {
		logic [1:0] reference;
		logic       left_adjust;
		logic [3:0] channel;
	} sac_selection_type;

	// conversion engine states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ALIGN   = 2'b01,
		ST_CONVERT = 2'b10
	} sac_state_type;

endpackage

// ### rtl/sac_ctrl.sv
`timescale 1ns/1ns
// Operation
// RULE_01: 10-bit result right aligned, left aligned when left_adjust set.
// RULE_02: software reads low byte then high, or only high byte for 8 bits.
// RULE_03: reading low byte blocks result updates until high byte read.
// RULE_04: completion while blocked changes neither byte, result discarded.
// RULE_05: reading high byte lifts the update block.
// RULE_06: completion flag still sets when the result is discarded.
// RULE_07: each finished conversion raises the converter's own event.
// RULE_08: start bit begins one conversion, reads high while busy, clears at end.
// RULE_09: channel written during conversion applies after it finishes.
// RULE_10: auto trigger enable lets the selected source start conversions.
// RULE_11: rising trigger edge resets prescaler and starts a conversion.
// RULE_12: trigger still high at completion does not restart.
// RULE_13: trigger edge during a conversion is ignored, never queued.
// RULE_14: trigger source flags set on events even without interrupts.
// RULE_15: software clears a source flag so its next event gives an edge.
// RULE_16: own done flag as trigger gives free running conversions.
// RULE_17: free running starts by start bit, continues regardless of flag.
// RULE_18: selections reach the converter only while converter_enable set.
// RULE_19: converter runs only while the power gate bit is zero.
// RULE_20: channel selects eight pins, ground or bandgap reference.
// RULE_21: code zero is ground, top code is reference minus one LSB.
// RULE_22: conversion is 13 converter clocks, first after enable is 25.
// RULE_23: completion writes result, sets flag, clears start in single mode.
// RULE_24: irq is done flag and its enable, qualified by global enable.
module sac_ctrl #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// axi4-lite write address and data
	input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// trigger sources
	input  wire logic                       ext_trigger_pin,
	input  wire logic [5:0]                 periph_event,
	// interrupt
	input  wire logic                       global_irq_enable,
	output logic                            irq,
	// analog front end
	input  wire logic [9:0]                 sar_code,
	output logic                            analog_enable,
	output logic                            sample_start,
	output sac_pkg::sac_selection_type      applied_sel,
	output logic                            conv_busy
);

	initial begin
		if (ADDR_W < 8) begin
			$error("sac_ctrl: ADDR_W must be at least 8");
		end
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [ADDR_W-1:0]            aw_addr_ff;
	logic                         aw_held_ff;
	logic [31:0]                  w_data_ff;
	logic                         w_strb0_ff;
	logic                         w_held_ff;
	logic                         bvalid_ff;
	logic [1:0]                   bresp_ff;
	logic                         rvalid_ff;
	logic [31:0]                  rdata_ff;
	logic [1:0]                   rresp_ff;
	logic                         wr_fire;
	logic                         rd_fire;
	logic [7:0]                   wr_byte;
	logic                         wr_hit_a;
	logic                         wr_hit_b;
	logic                         wr_hit_chan;
	logic                         wr_hit_trig;

	logic                         enable_ff;
	logic                         start_ff;
	logic                         auto_ff;
	logic                         done_ff;
	logic                         done_ie_ff;
	logic [2:0]                   presc_sel_ff;
	logic                         power_gate_ff;
	logic [2:0]                   tsel_ff;
	sac_pkg::sac_selection_type   sel_temp_ff;
	sac_pkg::sac_selection_type   sel_applied_ff;
	logic [9:0]                   result_ff;
	logic                         lock_ff;
	logic                         first_ff;
	logic [7:1]                   trig_flag_ff;
	logic [7:0]                   trig_set;
	logic                         trig_level;
	logic                         trig_prev_ff;
	logic                         trig_edge;

	logic                         pin_s1_ff;
	logic                         pin_s2_ff;
	logic                         pin_s3_ff;
	logic                         pin_stable_ff;

	logic [6:0]                   presc_cnt_ff;
	logic [6:0]                   presc_mask;
	logic                         tick;
	logic                         run_ok;
	sac_pkg::sac_state_type       state_ff;
	sac_pkg::sac_state_type       nxt_state;
	logic [4:0]                   tick_cnt_ff;
	logic [4:0]                   conv_len;
	logic                         finish;
	logic                         free_run;
	logic                         soft_start;
	logic                         auto_start;
	logic                         begin_req;

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready  = !w_held_ff && !bvalid_ff;
	assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_byte       = w_strb0_ff ? w_data_ff[7:0] : 8'h00;
	assign wr_hit_a      = wr_fire && w_strb0_ff && aw_addr_ff[7:0] == sac_pkg::OFS_CTRL_A;
	assign wr_hit_b      = wr_fire && w_strb0_ff && aw_addr_ff[7:0] == sac_pkg::OFS_CTRL_B;
	assign wr_hit_chan   = wr_fire && w_strb0_ff && aw_addr_ff[7:0] == sac_pkg::OFS_CHAN_REF;
	assign wr_hit_trig   = wr_fire && w_strb0_ff && aw_addr_ff[7:0] == sac_pkg::OFS_TRIG_FLAGS;

	// address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff  <= 32'h0000_0000;
			w_strb0_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff  <= 1'b1;
				w_data_ff  <= s_axi_wdata;
				w_strb0_ff <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	// write response, unmapped or upper bits of the address refused
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= sac_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= reg_mapped(aw_addr_ff) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// address decode shared by both channels
	function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
		logic hit;
		hit = (addr >> 8) == '0;
		return hit && (addr[7:0] == sac_pkg::OFS_CTRL_A || addr[7:0] == sac_pkg::OFS_CTRL_B ||
			addr[7:0] == sac_pkg::OFS_CHAN_REF || addr[7:0] == sac_pkg::OFS_RES_LOW ||
			addr[7:0] == sac_pkg::OFS_RES_HIGH || addr[7:0] == sac_pkg::OFS_TRIG_FLAGS);
	endfunction

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	assign s_axi_arready = !rvalid_ff;
	assign rd_fire       = s_axi_arvalid && !rvalid_ff;

	// read data registered, side effects happen at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= sac_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= reg_mapped(s_axi_araddr) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
			rdata_ff  <= {24'h00_0000, read_mux(s_axi_araddr)};
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

	// byte view of every register
	function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] addr);
		logic [7:0] val;
		val = 8'h00;
		if (reg_mapped(addr)) begin
			unique case (addr[7:0])
				sac_pkg::OFS_CTRL_A:     val = {enable_ff, start_ff, auto_ff, done_ff,
					done_ie_ff, presc_sel_ff};
				sac_pkg::OFS_CTRL_B:     val = {power_gate_ff, 4'h0, tsel_ff};
				sac_pkg::OFS_CHAN_REF:   val = {sel_temp_ff.reference, sel_temp_ff.left_adjust,
					1'b0, sel_temp_ff.channel};
				sac_pkg::OFS_RES_LOW:    val = sel_applied_ff.left_adjust ?
					{result_ff[1:0], 6'h00} : result_ff[7:0]; // RULE_01
				sac_pkg::OFS_RES_HIGH:   val = sel_applied_ff.left_adjust ?
					result_ff[9:2] : {6'h00, result_ff[9:8]}; // RULE_01
				sac_pkg::OFS_TRIG_FLAGS: val = {trig_flag_ff, 1'b0};
				default:                 val = 8'h00;
			endcase
		end
		return val;
	endfunction

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// plain settings, written whole from the low byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_ff     <= sac_pkg::RST_CTRL_A[sac_pkg::BIT_ENABLE];
			auto_ff       <= sac_pkg::RST_CTRL_A[sac_pkg::BIT_AUTO];
			done_ie_ff    <= sac_pkg::RST_CTRL_A[sac_pkg::BIT_DONE_IE];
			presc_sel_ff  <= sac_pkg::RST_CTRL_A[sac_pkg::PRESC_LSB +: sac_pkg::PRESC_W];
			power_gate_ff <= sac_pkg::RST_CTRL_B[sac_pkg::BIT_POWER_GATE];
			tsel_ff       <= sac_pkg::RST_CTRL_B[sac_pkg::TSEL_LSB +: sac_pkg::TSEL_W];
			sel_temp_ff   <= sac_pkg::RST_CHAN_REF[6:0];
		end else begin
			if (wr_hit_a) begin
				enable_ff    <= wr_byte[sac_pkg::BIT_ENABLE];
				auto_ff      <= wr_byte[sac_pkg::BIT_AUTO]; // RULE_10
				done_ie_ff   <= wr_byte[sac_pkg::BIT_DONE_IE];
				presc_sel_ff <= wr_byte[sac_pkg::PRESC_LSB +: sac_pkg::PRESC_W];
			end
			if (wr_hit_b) begin
				power_gate_ff <= wr_byte[sac_pkg::BIT_POWER_GATE];
				tsel_ff       <= wr_byte[sac_pkg::TSEL_LSB +: sac_pkg::TSEL_W];
			end
			if (wr_hit_chan) begin
				sel_temp_ff.reference   <= wr_byte[sac_pkg::REF_LSB +: 2];
				sel_temp_ff.left_adjust <= wr_byte[sac_pkg::BIT_LEFT];
				sel_temp_ff.channel     <= wr_byte[sac_pkg::CHAN_LSB +: sac_pkg::CHAN_W];
			end
		end
	end

	// ----------------------------------------
	// trigger sources
	// ----------------------------------------
	// pin synchroniser, a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_ff     <= 1'b0;
			pin_s2_ff     <= 1'b0;
			pin_s3_ff     <= 1'b0;
			pin_stable_ff <= 1'b0;
		end else begin
			pin_s1_ff <= ext_trigger_pin;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			if (pin_s2_ff == pin_s3_ff) begin
				pin_stable_ff <= pin_s3_ff;
			end
		end
	end

	assign trig_set = {periph_event, pin_s3_ff && (pin_s2_ff == pin_s3_ff) && !pin_stable_ff,
		1'b0};

	// sticky flags, set regardless of any mask; set wins over the clear
	generate
		for (genvar i = 1; i < 8; i++) begin : g_flag
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					trig_flag_ff[i] <= 1'b0;
				end else if (trig_set[i]) begin
					trig_flag_ff[i] <= 1'b1; // RULE_14
				end else if (wr_hit_trig && wr_byte[i]) begin
					trig_flag_ff[i] <= 1'b0; // RULE_15
				end
			end
		end
	endgenerate

	// only a fresh rising edge of the selected level counts
	assign trig_level = (tsel_ff == sac_pkg::TSEL_OWN_DONE) ? done_ff : trig_flag_ff[tsel_ff];
	assign trig_edge  = trig_level && !trig_prev_ff; // RULE_12

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_prev_ff <= 1'b0;
		end else begin
			trig_prev_ff <= trig_level;
		end
	end

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	assign run_ok     = enable_ff && !power_gate_ff; // RULE_19
	assign presc_mask = 7'h7F >> (3'd7 - ((presc_sel_ff == 3'd0) ? 3'd1 : presc_sel_ff));
	assign tick       = (presc_cnt_ff & presc_mask) == presc_mask;

	// held in reset while off, restarted by an auto trigger
	always_ff @(posedge aclk) begin
		if (!aresetn || !run_ok) begin
			presc_cnt_ff <= 7'h00;
		end else if (auto_start) begin
			presc_cnt_ff <= 7'h00; // RULE_11
		end else begin
			presc_cnt_ff <= presc_cnt_ff + 7'h01;
		end
	end

	// ----------------------------------------
	// conversion sequencing
	// ----------------------------------------
	assign soft_start = wr_hit_a && wr_byte[sac_pkg::BIT_START] && wr_byte[sac_pkg::BIT_ENABLE];
	assign auto_start = auto_ff && trig_edge && state_ff == sac_pkg::ST_IDLE && run_ok; // RULE_13
	assign begin_req  = state_ff == sac_pkg::ST_IDLE &&
		((soft_start && !power_gate_ff) || auto_start); // enable may come with the start write
	assign conv_len   = first_ff ? 5'(sac_pkg::FIRST_TICKS) : 5'(sac_pkg::NORMAL_TICKS); // RULE_22
	assign finish     = state_ff == sac_pkg::ST_CONVERT && tick && tick_cnt_ff == conv_len - 5'd1;
	assign free_run   = auto_ff && tsel_ff == sac_pkg::TSEL_OWN_DONE; // RULE_16

	// next state of the engine
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			sac_pkg::ST_IDLE: begin
				if (begin_req) begin
					nxt_state = sac_pkg::ST_ALIGN;
				end
			end
			sac_pkg::ST_ALIGN: begin
				if (tick) begin
					nxt_state = sac_pkg::ST_CONVERT;
				end
			end
			sac_pkg::ST_CONVERT: begin
				if (finish && !free_run) begin
					nxt_state = sac_pkg::ST_IDLE;
				end
			end
			default: nxt_state = sac_pkg::ST_IDLE;
		endcase
		if (!run_ok && !begin_req) begin
			nxt_state = sac_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= sac_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// converter clock count, restarts when free running carries on
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff != sac_pkg::ST_CONVERT || finish) begin
			tick_cnt_ff <= 5'd0;
		end else if (tick) begin
			tick_cnt_ff <= tick_cnt_ff + 5'd1;
		end
	end

	// first conversion after switching on runs longer for analog settling
	always_ff @(posedge aclk) begin
		if (!aresetn || !run_ok) begin
			first_ff <= 1'b1;
		end else if (finish) begin
			first_ff <= 1'b0;
		end
	end

	// start bit: high while busy; free running keeps it high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_ff <= 1'b0;
		end else if (begin_req) begin
			start_ff <= 1'b1; // RULE_08 RULE_17
		end else if (!run_ok || (finish && !free_run)) begin
			start_ff <= 1'b0; // RULE_23
		end
	end

	// completion flag, set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_ff <= 1'b0;
		end else if (finish) begin
			done_ff <= 1'b1; // RULE_06 RULE_07 RULE_23
		end else if (wr_hit_a && wr_byte[sac_pkg::BIT_DONE]) begin
			done_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// selection buffer and result
	// ----------------------------------------
	// selections follow the temporary copy while enabled and idle, at each conversion finish, and on a start request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_applied_ff <= sac_pkg::RST_CHAN_REF[6:0];
		end else if ((run_ok && (state_ff == sac_pkg::ST_IDLE || finish)) || begin_req) begin
			sel_applied_ff <= sel_temp_ff; // RULE_09 RULE_18 RULE_20
		end
	end

	// result capture, code zero means ground and full scale is reference less one lsb
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_ff <= 10'h000;
		end else if (finish && !lock_ff) begin
			result_ff <= sar_code; // RULE_01 RULE_04 RULE_21 RULE_23
		end
	end

	// read lock; a high-byte read in the same cycle clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_ff <= 1'b0;
		end else if (rd_fire && s_axi_araddr == ADDR_W'(sac_pkg::OFS_RES_HIGH)) begin
			lock_ff <= 1'b0; // RULE_05
		end else if (rd_fire && s_axi_araddr == ADDR_W'(sac_pkg::OFS_RES_LOW)) begin
			lock_ff <= 1'b1; // RULE_03
		end
	end

	// ----------------------------------------
	// outputs to the front end and interrupt
	// ----------------------------------------
	assign irq           = done_ff && done_ie_ff && global_irq_enable; // RULE_24
	assign analog_enable = run_ok;
	assign sample_start  = run_ok && ((state_ff == sac_pkg::ST_ALIGN && tick) ||
		(finish && free_run)); // RULE_16
	assign applied_sel   = sel_applied_ff;
	assign conv_busy     = state_ff != sac_pkg::ST_IDLE;

endmodule

// ### sim/sac_ctrl_chk_properties.sv
`timescale 1ns/1ns
module sac_ctrl_chk (
	// clock and reset
	input wire logic                       aclk,
	input wire logic                       aresetn,
	// register bus
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	// converter side
	input wire logic                       global_irq_enable,
	input wire logic                       irq,
	input wire logic                       analog_enable,
	input wire logic                       sample_start,
	input wire logic                       conv_busy,
	input wire sac_pkg::sac_selection_type applied_sel
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// busy cycles since the last sample start; a first run at the slowest divide is the longest
	localparam int RUN_MAX = 3200;
	logic [11:0] run_cnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || sample_start || !conv_busy) begin
			run_cnt_ff <= 12'h000;
		end else if (run_cnt_ff != 12'hFFF) begin
			run_cnt_ff <= run_cnt_ff + 12'h001;
		end
	end

	// ----------------------------------------
	// converter timing and gating
	// ----------------------------------------
	irq_gate_a: assert property (!global_irq_enable |-> !irq)
		else $error("irq raised with global enable off");
	start_power_a: assert property (sample_start |-> analog_enable && conv_busy)
		else $error("sample start while gated or idle");
	// an abort by gating may cut the run short, nothing else may
	conv_len_a: assert property (sample_start |-> (conv_busy || !analog_enable)[*8])
		else $error("conversion ended too soon");
	conv_end_a: assert property (run_cnt_ff <= RUN_MAX)
		else $error("conversion never finished");
	sel_hold_a: assert property (!analog_enable ##1 !analog_enable |-> $stable(applied_sel))
		else $error("selection applied while disabled");

	// ----------------------------------------
	// register bus answers
	// ----------------------------------------
	r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data above byte lane");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
endmodule

// ### sim/sac_ctrl_tb_top.sv
`timescale 1ns/1ns
module sac_ctrl_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, global_irq_enable = 1'b1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_trigger_pin = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [5:0]  periph_event = 6'h00;
	logic [9:0]  sar_code = 10'h000, c;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        irq, analog_enable, sample_start, conv_busy;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [33:0] exp_q[$];
	int          n_mismatch = 0, num_checks = 0, seed = 32'h4bbcac73, n, s, starts = 0;
	sac_pkg::sac_selection_type applied_sel;

	sac_ctrl u_dut (.*);

	always #5 aclk = ~aclk;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// oldest note against each read answer
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata} === exp_q.pop_front(), "read data");

	// start pulses counted so lost or queued triggers show up
	always @(posedge aclk)
		if (sample_start === 1'b1)
			starts++;

	// ----------------------------------------
	// bus and trigger drivers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp === r, "write response");
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		exp_q.push_back({r, 24'h000000, d});
		do
			@(posedge aclk);
		while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	task automatic pulse();
		@(posedge aclk);
		periph_event <= 6'h01;
		@(posedge aclk);
		periph_event <= 6'h00;
		repeat (5) @(posedge aclk);
	endtask

	task automatic idle(output int k);
		k = 0;
		while (conv_busy !== 1'b0) begin
			@(posedge aclk);
			k++;
		end
	endtask

	task automatic conv(input logic [7:0] ctl);
		c = 10'($random(seed));
		sar_code <= c;
		wr(sac_pkg::OFS_CTRL_A, ctl);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(sac_pkg::OFS_CTRL_A, sac_pkg::RST_CTRL_A);
		rd(sac_pkg::OFS_CTRL_B, sac_pkg::RST_CTRL_B);
		rd(sac_pkg::OFS_CHAN_REF, sac_pkg::RST_CHAN_REF);
		wr(8'h18, 8'hFF, sac_pkg::RESP_SLVERR);
		rd(8'h18, 8'h00, sac_pkg::RESP_SLVERR);
		wr(sac_pkg::OFS_CHAN_REF, 8'h03);
		chk(applied_sel.channel === 4'h0, "selection while off");
		conv(8'hC8);
		idle(n);
		chk(n >= sac_pkg::FIRST_TICKS - 1, "first length");
		chk(applied_sel.channel === 4'h3 && irq === 1'b1, "done irq");
		rd(sac_pkg::OFS_CTRL_A, 8'h98);
		rd(sac_pkg::OFS_RES_LOW, c[7:0]);
		rd(sac_pkg::OFS_RES_HIGH, {6'h00, c[9:8]});
		// prescale code 1 divides by two like code 0; the run stays open across the next bus cycles
		conv(8'hD9);
		rd(sac_pkg::OFS_CTRL_A, 8'hC9);
		wr(sac_pkg::OFS_CHAN_REF, 8'h05);
		chk(applied_sel.channel === 4'h3, "selection mid run");
		idle(n);
		@(posedge aclk);
		chk(applied_sel.channel === 4'h5, "selection after run");
		rd(sac_pkg::OFS_RES_LOW, c[7:0]);
		sar_code <= ~c;
		wr(sac_pkg::OFS_CTRL_A, 8'hD9);
		idle(n);
		chk(irq === 1'b1, "irq on lost result");
		rd(sac_pkg::OFS_RES_HIGH, {6'h00, c[9:8]});
		wr(sac_pkg::OFS_CHAN_REF, 8'hA5);
		conv(8'hD9);
		idle(n);
		chk(applied_sel === 7'h55, "applied selection");
		rd(sac_pkg::OFS_RES_LOW, {c[1:0], 6'h00});
		rd(sac_pkg::OFS_RES_HIGH, c[9:2]);
		global_irq_enable <= 1'b0;
		wr(sac_pkg::OFS_CTRL_B, 8'h02);
		wr(sac_pkg::OFS_CTRL_A, 8'hB9);
		s = starts;
		pulse();
		chk(conv_busy === 1'b1, "trigger start");
		wr(sac_pkg::OFS_TRIG_FLAGS, 8'h04);
		pulse();
		idle(n);
		repeat (40) @(posedge aclk);
		chk(starts == s + 1 && irq === 1'b0, "edge queued");
		rd(sac_pkg::OFS_TRIG_FLAGS, 8'h04);
		wr(sac_pkg::OFS_TRIG_FLAGS, 8'h04);
		pulse();
		chk(conv_busy === 1'b1 && starts == s + 2, "fresh edge");
		idle(n);
		// pin source, settled through the synchroniser before it counts
		wr(sac_pkg::OFS_CTRL_B, 8'h01);
		ext_trigger_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		chk(starts == s + 3, "pin edge");
		ext_trigger_pin <= 1'b0;
		idle(n);
		wr(sac_pkg::OFS_CTRL_B, 8'h00);
		s = starts;
		wr(sac_pkg::OFS_CTRL_A, 8'hE9);
		repeat (150) @(posedge aclk);
		chk(starts >= s + 4, "free run");
		wr(sac_pkg::OFS_CTRL_B, 8'h80);
		@(posedge aclk);
		chk(analog_enable === 1'b0 && conv_busy === 1'b0, "gated");
		wrap_up();
	end

	// a hung handshake ends the run here
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
endmodule

bind sac_ctrl sac_ctrl_chk u_chk (.*);
